//--- rtl/proximity_card_line_coder_defs.vh
/*
  Constants for the proximity card line coder: protocol and rate codes,
  bit period and subcarrier counts, CRC presets and polynomial, states.
  Assumes one clk cycle stands for one carrier period of the RF field.
*/
`ifndef PROXIMITY_CARD_LINE_CODER_DEFS_VH
`define PROXIMITY_CARD_LINE_CODER_DEFS_VH

// Protocol select and depth codes.
`define PROTO_A        1'h0
`define PROTO_B        1'h1
`define DEPTH_FULL     1'h0
`define DEPTH_TEN      1'h1

// Rate codes: 106, 212, 424, 848 kbit/s.
`define RATE_106       2'h0

// Bit period at 106 kbit/s in carrier periods, halved per rate step.
`define BIT_PERIOD_106 8'h80
// Subcarrier period is 16 carrier periods; bit 3 of the count is its phase.
`define SUBC_PHASE_BIT 3
`define SUBC_QUARTER   8'h04

// CRC: reflected polynomial, presets per protocol.
`define CRC_POLY       16'h8408
`define CRC_PRESET_A   16'h6363
`define CRC_PRESET_B   16'hffff

// Miller symbols.
`define SYM_Y          2'h0
`define SYM_X          2'h1
`define SYM_Z          2'h2

// States.
`define ST_IDLE        2'h0
`define ST_TX          2'h1
`define ST_RX          2'h2

`endif

//--- rtl/proximity_card_line_coder.v
/*
  Bit-level line coder for a proximity reader/card front end: downlink
  Miller or NRZ keying, card-mode subcarrier coding, uplink Manchester and
  BPSK decoding, and a frame CRC over transmitted data bits.
  Assumes clk is derived from the carrier, one cycle per carrier period,
  and that the host above runs all protocol sequencing.
*/
`timescale 1ns/1ps
`default_nettype none
`include "proximity_card_line_coder_defs.vh"

module proximity_card_line_coder (
  input  wire        clk,
  input  wire        rst,
  input  wire        proto_b,
  input  wire [1:0]  rate,
  input  wire        card_mode,
  input  wire        tx_valid,
  input  wire        tx_data,
  input  wire        tx_par,
  input  wire        tx_last,
  output wire        tx_ready,
  output wire        tx_busy,
  output wire        mod_on,
  output wire        mod_depth,
  input  wire        rx_enable,
  input  wire        rx_in,
  output wire        rx_valid,
  output wire        rx_data,
  output wire [15:0] crc_out
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Bit period in carrier periods for a rate code.
  function [7:0] bit_period;
    input [1:0] r;
    begin
      bit_period = `BIT_PERIOD_106 >> r;
    end
  endfunction

  // One reflected CRC step over a single bit.
  function [15:0] crc_step;
    input [15:0] c;
    input        b;
    begin
      crc_step = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? `CRC_POLY : 16'h0000);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers.

  reg  [1:0]  state_r;
  reg         proto_r;
  reg  [1:0]  rate_r;
  reg         card_r;
  reg  [7:0]  cnt_r;
  reg         cur_r;
  reg         prev_r;
  reg         first_r;
  reg         last_r;
  reg  [1:0]  sym_r;
  reg         tx_ready_r;
  reg         tx_busy_r;
  reg         mod_on_r;
  reg         mod_depth_r;
  reg         rx_valid_r;
  reg         rx_data_r;
  reg  [15:0] crc_r;
  reg  [15:0] crc_out_r;
  reg         rx_s1_r;
  reg         rx_s2_r;
  reg         rx_s3_r;
  reg         rx_lvl_r;
  reg         rx_old_r;
  reg  [3:0]  edges_a_r;
  reg  [3:0]  edges_b_r;
  reg         phase_r;
  reg         ref_r;

  wire        idle    = (state_r == `ST_IDLE);
  // frame config latch
  // Inputs steer the first bit only; afterwards the latched copy rules.
  wire        proto_e = idle ? proto_b   : proto_r;
  wire [1:0]  rate_e  = idle ? rate      : rate_r;
  wire        card_e  = idle ? card_mode : card_r;
  wire [7:0]  period  = bit_period(rate_e);
  wire        end_bit = (cnt_r == period - 8'h01);
  wire        take    = tx_valid &
                        ((idle & ~rx_enable) |
                         ((state_r == `ST_TX) & end_bit & ~last_r));
  wire        inv     = card_e & (rate_e != `RATE_106) & tx_par & tx_last;
  wire        bit_in  = tx_data ^ inv;
  wire        rx_edge = rx_lvl_r ^ rx_old_r;
  wire [7:0]  half    = period >> 1;
  // next CRC value
  // A bit taken from idle starts from the preset of the incoming protocol.
  wire [15:0] crc_nxt = crc_step(idle ? ((proto_b == `PROTO_B) ?
                                         `CRC_PRESET_B : `CRC_PRESET_A) :
                                        crc_r, tx_data);

  ////////////////////////////////////////////////////////////////////////
  // Transmit symbol shaping for the bit in flight.

  reg mod_nxt;
  always @* begin
    mod_nxt = 1'b0;
    if (state_r == `ST_TX) begin
      if (card_r) begin
        if (rate_r == `RATE_106) begin
          // Manchester: subcarrier in the first half for a one.
          mod_nxt = cnt_r[`SUBC_PHASE_BIT] &
                    (cur_r ? (cnt_r < half) : (cnt_r >= half));
        end else begin
          // BPSK: a zero flips the subcarrier phase.
          mod_nxt = cnt_r[`SUBC_PHASE_BIT] ^ ~cur_r;
        end
      end else if (proto_r == `PROTO_B) begin
        mod_nxt = ~cur_r;
      end else begin
        case (sym_r)
          `SYM_Z:  mod_nxt = (cnt_r < (half >> 1));
          `SYM_X:  mod_nxt = (cnt_r >= half) &
                             (cnt_r < half + (half >> 1));
          default: mod_nxt = 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive input synchroniser; a change counts when stages two and three
  // agree, which also rejects single-cycle glitches on the pin.

  always @(posedge clk) begin
    if (rst) begin
      rx_s1_r  <= 1'b0;
      rx_s2_r  <= 1'b0;
      rx_s3_r  <= 1'b0;
      rx_lvl_r <= 1'b0;
      rx_old_r <= 1'b0;
    end else begin
      rx_s1_r  <= rx_in;
      rx_s2_r  <= rx_s1_r;
      rx_s3_r  <= rx_s2_r;
      rx_lvl_r <= (rx_s2_r == rx_s3_r) ? rx_s3_r : rx_lvl_r;
      rx_old_r <= rx_lvl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer, bit timing, CRC and uplink decoding.

  always @(posedge clk) begin
    if (rst) begin
      state_r     <= `ST_IDLE;
      proto_r     <= `PROTO_A;
      rate_r      <= `RATE_106;
      card_r      <= 1'b0;
      cnt_r       <= 8'h00;
      cur_r       <= 1'b0;
      prev_r      <= 1'b0;
      first_r     <= 1'b1;
      last_r      <= 1'b0;
      sym_r       <= `SYM_Y;
      tx_ready_r  <= 1'b0;
      tx_busy_r   <= 1'b0;
      mod_on_r    <= 1'b0;
      mod_depth_r <= `DEPTH_FULL;
      rx_valid_r  <= 1'b0;
      rx_data_r   <= 1'b0;
      crc_r       <= `CRC_PRESET_A;
      crc_out_r   <= `CRC_PRESET_A;
      edges_a_r   <= 4'h0;
      edges_b_r   <= 4'h0;
      phase_r     <= 1'b0;
      ref_r       <= 1'b0;
    end else begin
      tx_ready_r <= take;
      rx_valid_r <= 1'b0;
      mod_on_r   <= mod_nxt;
      cnt_r      <= (idle | end_bit) ? 8'h00 : cnt_r + 8'h01;
      case (state_r)
        `ST_IDLE: begin
          tx_busy_r <= 1'b0;
          if (take | rx_enable) begin
            proto_r <= proto_b;
            rate_r  <= rate;
            card_r  <= card_mode;
            mod_depth_r <= (proto_b == `PROTO_B) ? `DEPTH_TEN : `DEPTH_FULL;
            crc_r <= (proto_b == `PROTO_B) ? `CRC_PRESET_B : `CRC_PRESET_A;
            crc_out_r <= (proto_b == `PROTO_B) ? ~`CRC_PRESET_B
                                               : `CRC_PRESET_A;
            first_r   <= 1'b1;
            edges_a_r <= 4'h0;
            edges_b_r <= 4'h0;
          end
          if (take) begin
            state_r   <= `ST_TX;
            tx_busy_r <= 1'b1;
          end else if (rx_enable) begin
            state_r <= `ST_RX;
          end
        end
        `ST_TX: begin
          if (end_bit & ~take) begin
            // Last bit sent or host underran: the frame ends here.
            state_r   <= `ST_IDLE;
            tx_busy_r <= 1'b0;
          end
        end
        `ST_RX: begin
          // Half-bit activity counts, saturating, for Manchester.
          if (rx_edge & (cnt_r < half) & (edges_a_r != 4'hf))
            edges_a_r <= edges_a_r + 4'h1;
          if (rx_edge & (cnt_r >= half) & (edges_b_r != 4'hf))
            edges_b_r <= edges_b_r + 4'h1;
          // sixteen-carrier subcarrier phase
          // Sample a quarter subcarrier past mid-bit for BPSK phase.
          if (cnt_r == half + `SUBC_QUARTER)
            phase_r <= rx_lvl_r;
          if (end_bit) begin
            edges_a_r <= 4'h0;
            edges_b_r <= 4'h0;
            first_r   <= 1'b0;
            if (~card_r & (proto_r == `PROTO_A) & (rate_r == `RATE_106)) begin
              // Manchester uplink
              // A bit counts only when exactly one half carried subcarrier.
              if ((edges_a_r > 4'h1) != (edges_b_r > 4'h1)) begin
                rx_valid_r <= 1'b1;
                rx_data_r  <= (edges_a_r > 4'h1);
              end
            end else if (first_r) begin
              // BPSK reference phase
              // The first bit sets the phase that decodes as zero.
              ref_r <= phase_r;
            end else begin
              rx_valid_r <= 1'b1;
              rx_data_r  <= phase_r ^ ref_r;
            end
          end
          if (~rx_enable)
            state_r <= `ST_IDLE;
        end
        default: state_r <= `ST_IDLE;
      endcase
      // Load the next downlink bit and its Miller symbol.
      if (take) begin
        cur_r   <= bit_in;
        prev_r  <= bit_in;
        first_r <= 1'b0;
        last_r  <= tx_last;
        sym_r   <= bit_in ? `SYM_X :
                   ((idle | ~prev_r) ? `SYM_Z : `SYM_Y);
        if (~tx_par) begin
          crc_r     <= crc_nxt;
          crc_out_r <= (proto_e == `PROTO_B) ? ~crc_nxt : crc_nxt;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops. Type B CRC is sent complemented.

  assign tx_ready  = tx_ready_r;
  assign tx_busy   = tx_busy_r;
  assign mod_on    = mod_on_r;
  assign mod_depth = mod_depth_r;
  assign rx_valid  = rx_valid_r;
  assign rx_data   = rx_data_r;
  assign crc_out   = crc_out_r;

endmodule // proximity_card_line_coder

`default_nettype wire

//--- dv/proximity_card_line_coder_props.sv
/* Port checker for the line coder.
   Assumes clk is the carrier clock and rst is synchronous. */
`timescale 1ns/1ps
`default_nettype none
module line_coder_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        proto_b,
  input wire logic [1:0]  rate,
  input wire logic        card_mode,
  input wire logic        tx_valid,
  input wire logic        tx_data,
  input wire logic        tx_par,
  input wire logic        tx_last,
  input wire logic        tx_ready,
  input wire logic        tx_busy,
  input wire logic        mod_on,
  input wire logic        mod_depth,
  input wire logic        rx_enable,
  input wire logic        rx_in,
  input wire logic        rx_valid,
  input wire logic        rx_data,
  input wire logic [15:0] crc_out
);
  logic [7:0] gap_r;
  logic [1:0] lrate_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since the last taken bit; rate latched once per frame.
  always @(posedge clk) begin
    gap_r <= tx_ready ? 8'h01 : gap_r + 8'h01;
    if (tx_ready && $rose(tx_busy)) lrate_r <= $past(rate);
  end
  // Miller symbols at 848 kbit/s: X pauses in the third quarter.
  sequence sym_x; !mod_on [*8] ##1 mod_on [*4] ##1 !mod_on; endsequence
  sequence sym_z; mod_on [*4] ##1 !mod_on; endsequence
  // Card subcarrier at 106 kbit/s: one burst of eight carriers, then off.
  sequence sub_burst; !mod_on [*8] ##1 mod_on [*8] ##1 !mod_on; endsequence
  ////////////////////////////////////////
  AST_READY_PULSE: assert property (tx_ready |=> !tx_ready)
    else $error("tx_ready held too long");
  AST_READY_BUSY: assert property (tx_ready |-> tx_busy)
    else $error("bit taken outside a frame");
  AST_IDLE_QUIET: assert property (!tx_busy && !$past(tx_busy) |-> !mod_on)
    else $error("modulation while idle");
  AST_PERIOD: assert property (tx_ready && !$rose(tx_busy) |->
    gap_r == (8'h80 >> lrate_r)) else $error("bit period wrong");
  AST_A_ZERO: assert property ($rose(tx_busy) && $past(rate) == 2'h3 &&
    !$past(proto_b) && !$past(card_mode) && !$past(tx_data)
    |=> !mod_depth ##0 sym_z) else $error("bad first zero symbol");
  AST_A_ONE: assert property ($rose(tx_busy) && $past(rate) == 2'h3 &&
    !$past(proto_b) && !$past(card_mode) && $past(tx_data)
    |=> !mod_depth ##0 sym_x) else $error("bad one symbol");
  AST_B_NRZ: assert property ($rose(tx_busy) && $past(proto_b) &&
    !$past(card_mode) |=> (mod_depth && mod_on == !$past(tx_data, 2))
    ##1 $stable(mod_on) [*8]) else $error("bad type B keying");
  AST_CRC_TAKE: assert property ($changed(crc_out) |->
    tx_ready || $past(rx_enable)) else $error("crc moved without a bit");
  AST_RX_PULSE: assert property (rx_valid |=> !rx_valid)
    else $error("rx_valid held too long");
  AST_CARD_MAN: assert property ($rose(tx_busy) && $past(rate) == 2'h0 &&
    !$past(proto_b) && $past(card_mode) && $past(tx_data)
    |=> sub_burst ##56 !mod_on) else $error("bad card Manchester one");
endmodule // line_coder_props
bind proximity_card_line_coder line_coder_props props (
  .clk(clk), .rst(rst), .proto_b(proto_b), .rate(rate),
  .card_mode(card_mode), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_par(tx_par), .tx_last(tx_last), .tx_ready(tx_ready),
  .tx_busy(tx_busy), .mod_on(mod_on), .mod_depth(mod_depth),
  .rx_enable(rx_enable), .rx_in(rx_in), .rx_valid(rx_valid),
  .rx_data(rx_data), .crc_out(crc_out));
`default_nettype wire

//--- dv/card_model.sv
/* Behavioural card answering with subcarrier load modulation.
   Assumes frames start when active rises and bits[0] is 0. */
`timescale 1ns/1ps
`default_nettype none
module card_model (
  input  wire logic       clk,
  input  wire logic       active,
  input  wire logic       manch,
  input  wire logic [1:0] rate,
  input  wire logic [7:0] bits,
  output var  logic       load
);
  logic [9:0] t_r;
  logic       b;
  // Frame timer; it wraps after eight bits at the slowest rate.
  always @(posedge clk)
    t_r <= active ? t_r + 10'h001 : 10'h000;
  ////////////////////////////////////////
  // subcarrier coding
  always @* begin
    b = bits[3'(t_r >> (3'h7 - {1'b0, rate}))];
    if (!active) load = 1'b0;
    else if (manch) load = t_r[3] & (t_r[6] ^ b);
    else load = t_r[3] ^ b;
  end
endmodule // card_model
`default_nettype wire

//--- dv/proximity_card_line_coder_tb_top.sv
/* Self-checking bench for the line coder with a card model.
   Assumes one clk cycle per carrier period. */
`timescale 1ns/1ps
`default_nettype none
module proximity_card_line_coder_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        proto_b = 1'b0;
  logic [1:0]  rate = 2'h0;
  logic        card_mode = 1'b0;
  logic        tx_valid = 1'b0;
  logic        tx_data = 1'b0;
  logic        tx_par = 1'b0;
  logic        tx_last = 1'b0;
  logic        rx_enable = 1'b0;
  logic        manch = 1'b0;
  logic [15:0] mo;
  logic        dp;
  wire         tx_ready, tx_busy, mod_on, mod_depth, rx_in, rx_valid, rx_data;
  wire  [15:0] crc_out;
  int          num_errors = 0;
  int          checks = 0;
  proximity_card_line_coder dut (.clk(clk), .rst(rst), .proto_b(proto_b),
    .rate(rate), .card_mode(card_mode), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_par(tx_par), .tx_last(tx_last),
    .tx_ready(tx_ready), .tx_busy(tx_busy), .mod_on(mod_on),
    .mod_depth(mod_depth), .rx_enable(rx_enable), .rx_in(rx_in),
    .rx_valid(rx_valid), .rx_data(rx_data), .crc_out(crc_out));
  card_model partner (.clk(clk), .active(rx_enable), .manch(manch),
    .rate(rate), .bits(8'hb6), .load(rx_in));
  // Carrier clock, 40 ns period.
  always #20 clk = ~clk;
  ////////////////////////////////////////
  function automatic logic [15:0] crc_of(input logic p, input logic [7:0] d);
    logic [15:0] c;
    c = p ? 16'hffff : 16'h6363;
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'h8408 : 16'h0);
    return p ? ~c : c;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait: 0 ready, 1 busy low, 2 received bit.
  task automatic wait_for(input int which);
    for (int w = 0; w < 5000; w++) begin
      @(negedge clk);
      if (which == 0 && tx_ready === 1'b1) return;
      if (which == 1 && tx_busy === 1'b0) return;
      if (which == 2 && rx_valid === 1'b1) return;
    end
    num_errors++;
    results;
  endtask
  // bench host sequencing
  // Sends n bits; mo keeps mod_on at the first cycle of each bit.
  task automatic send(input logic p, input logic [1:0] r, input logic cm,
                      input int n, input logic [15:0] d, input logic [15:0] pm);
    @(posedge clk);
    {proto_b, rate, card_mode} <= {p, r, cm};
    for (int k = 0; k < n; k++) begin
      tx_valid <= 1'b1;
      {tx_data, tx_par, tx_last} <= {d[k], pm[k], k == n - 1};
      wait_for(0);
      @(negedge clk);
      mo[k] = mod_on;
      if (k == 0) dp = mod_depth;
      @(posedge clk);
      // Mid-frame select changes must be ignored until the next frame.
      {proto_b, rate, card_mode} <= ~{p, r, cm};
    end
    tx_valid <= 1'b0;
    wait_for(1);
  endtask
  task automatic t_rates;
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 4; r++) begin
        send(p[0], r[1:0], 1'b0, 3, 16'h0002, 16'h0);
        chk(16'(mo[2:0]), p ? 16'h5 : 16'h1);
        chk(16'(dp), 16'(p[0]));
      end
    end
    send(1'b0, 2'h3, 1'b0, 2, 16'h0001, 16'h0);
    chk(16'(mo[1:0]), 16'h0);
    send(1'b0, 2'h1, 1'b1, 3, 16'h0005, 16'h0004);
    chk(16'(mo[2:0]), 16'h6);
    send(1'b0, 2'h0, 1'b1, 2, 16'h0001, 16'h0);
    chk(16'(mo[1:0]), 16'h0);
    $display("rate, symbol and parity test done");
  endtask
  task automatic t_crc;
    for (int p = 0; p < 2; p++) begin
      send(p[0], 2'h2, 1'b0, 9, 16'h015a, 16'h0100);
      chk(crc_out, crc_of(p[0], 8'h5a));
    end
    $display("crc test done");
  endtask
  task automatic t_rx(input logic p, input logic [1:0] r);
    logic [7:0] got;
    @(posedge clk);
    {proto_b, rate, card_mode, rx_enable} <= {p, r, 2'h1};
    manch <= !p && r == 2'h0;
    for (int k = 0; k < 7; k++) begin
      wait_for(2);
      got[k] = rx_data;
    end
    @(posedge clk);
    rx_enable <= 1'b0;
    chk(16'(got[6:0]), manch ? 16'h36 : 16'h5b);
    $display("receive test done");
  endtask
  task automatic t_reset;
    @(negedge clk);
    chk(16'({tx_ready, tx_busy, mod_on, mod_depth, rx_valid}), 16'h0);
    chk(crc_out, 16'h6363);
    $display("reset test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_rates;
    t_crc;
    t_rx(1'b0, 2'h0);
    t_rx(1'b1, 2'h1);
    t_rx(1'b0, 2'h3);
    results;
  end
endmodule // proximity_card_line_coder_tb_top
`default_nettype wire
